// ---- pm_brake_sva.sv ----
// port checker for the braking and field-weakening block
// assumes one clock, core_clk, and the async low reset rst_b
`timescale 1ns/100ps
module pm_brake_sva #(
	parameter int DW = 16
) (
	// clock and reset
	input wire logic                 core_clk,
	input wire logic                 rst_b,
	// bus handshake
	input wire logic                 read,
	input wire logic                 write,
	input wire logic                 waitrequest,
	// control path
	input wire logic                 ctrl_tick,
	input wire logic                 fault,
	input wire logic signed [DW-1:0] speed_pi_out,
	input wire logic signed [DW-1:0] torque_ref,
	input wire logic signed [DW-1:0] id_cmd,
	input wire logic signed [DW-1:0] fw_d_current_cmd,
	// inverter side
	input wire logic [2:0]           gate_high,
	input wire logic [2:0]           gate_low,
	input wire logic                 critical_overvoltage_cmd
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	sequence s_taken;
		(read || write) && waitrequest;
	endsequence
	sequence s_answer;
		!waitrequest ##1 waitrequest;
	endsequence
	a_bus_answer: assert property (s_taken |=> s_answer)
		else $error("bus request not answered after one wait");
	a_bus_idle: assert property (!read && !write && waitrequest |=> waitrequest)
		else $error("bus answer without a request");
	a_ov_low_side: assert property (
		critical_overvoltage_cmd |=> gate_high == 3'h0 && gate_low == 3'h7)
		else $error("low-side zero vector not forced");
	a_ov_hold: assert property (
		critical_overvoltage_cmd [*2] |-> gate_high == 3'h0 && gate_low == 3'h7)
		else $error("forced zero vector dropped early");
	a_fault_off: assert property (
		fault && !critical_overvoltage_cmd |=> gate_high == 3'h0 && gate_low == 3'h0)
		else $error("gates active during fault");
	a_no_shoot: assert property ((gate_high & gate_low) == 3'h0)
		else $error("both switches of a leg on");
	a_torque_pass: assert property (
		ctrl_tick && !speed_pi_out[DW-1] |=> torque_ref == $past(speed_pi_out))
		else $error("positive torque reference altered");
	a_fw_nonpos: assert property (!(fw_d_current_cmd > 0))
		else $error("positive field-weakening current");
	a_id_below_fw: assert property (
		ctrl_tick |=> id_cmd <= $past(fw_d_current_cmd))
		else $error("d current above field-weakening share");
endmodule : pm_brake_sva

bind pm_motor_fieldweak_braking pm_brake_sva #(.DW(DW)) u_pm_brake_sva (
	.core_clk(core_clk), .rst_b(rst_b), .read(read), .write(write),
	.waitrequest(waitrequest), .ctrl_tick(ctrl_tick), .fault(fault),
	.speed_pi_out(speed_pi_out), .torque_ref(torque_ref), .id_cmd(id_cmd),
	.fw_d_current_cmd(fw_d_current_cmd), .gate_high(gate_high),
	.gate_low(gate_low), .critical_overvoltage_cmd(critical_overvoltage_cmd)
);

// ---- pm_drive_pkg.sv ----
// pm_drive_pkg: register map, field layout, reset values and timing
// constants shared by the motor braking / field-weakening block.
// assumes a 32-bit Avalon-MM slave with byte addresses, one word each.
package pm_drive_pkg;
	localparam int          ADDR_W        = 6;
	localparam logic [5:0]  REG_CTRL      = 6'h00;
	localparam logic [5:0]  REG_ANG_SLOPE = 6'h04;
	localparam logic [5:0]  REG_ANG_MAX   = 6'h08;
	localparam logic [5:0]  REG_FW_THR    = 6'h0C;
	localparam logic [5:0]  REG_FW_KI     = 6'h10;
	localparam logic [5:0]  REG_REGEN     = 6'h14;
	localparam logic [5:0]  REG_CRIT_LVL  = 6'h18;
	localparam logic [5:0]  REG_STATUS    = 6'h1C;
	localparam logic [5:0]  REG_IRQ_STAT  = 6'h20;
	localparam logic [5:0]  REG_IRQ_MASK  = 6'h24;
	localparam logic [5:0]  REG_FW_ID     = 6'h28;
	// control word fields
	localparam int          CTRL_RUN      = 0;
	localparam int          CTRL_ZV_REQ   = 1;
	localparam int          CTRL_SEQ_LSB  = 4;
	localparam int          SEQ_W         = 2;
	localparam logic [1:0]  SEQ_STOP      = 2'h0;
	localparam logic [1:0]  SEQ_RUN       = 2'h1;
	localparam logic [1:0]  SEQ_ZVB       = 2'h3;
	// interrupt / status bits
	localparam int          IRQ_W         = 3;
	localparam int          EV_CRIT_OV    = 0;
	localparam int          EV_FW_ON      = 1;
	localparam int          EV_REGEN      = 2;
	localparam int          ST_MODE_LSB   = 4;
	// reset values
	localparam logic [15:0] RST_ANG_SLOPE = 16'h0040;
	localparam logic [7:0]  RST_ANG_MAX   = 8'h40;
	localparam logic [15:0] RST_FW_THR    = 16'h6CCC;
	localparam logic [15:0] RST_FW_KI     = 16'h0010;
	localparam logic [15:0] RST_REGEN     = 16'h0000;
	localparam logic [15:0] RST_CRIT_LVL  = 16'h7000;
	// angle scale: 128 counts is a quarter turn, table step 8 counts
	localparam int          ANG_W         = 8;
	localparam int          ANG_IDX_LSB   = 3;
	localparam int          SLOPE_SHIFT   = 8;
	localparam int          TRIG_SHIFT    = 15;
	localparam logic [4:0]  LUT_TOP       = 5'h10;
	// field-weakening loop response as tuned for the default gain
	localparam int          FW_RESPONSE_MS = 250;
	localparam int          CLK_MHZ        = 125;
	localparam int          FW_FREQ_FLOOR  = 4;
	typedef enum logic [1:0] {MODE_STOP, MODE_RUN, MODE_ZVB} drive_mode_e;

	// quarter-wave sine in Q15, index 0..16 spans 0..90 degrees
	function automatic logic [15:0] sine_q15(input logic [4:0] idx);
		unique case (idx)
			5'h00: sine_q15 = 16'h0000;
			5'h01: sine_q15 = 16'h0C8C;
			5'h02: sine_q15 = 16'h18F9;
			5'h03: sine_q15 = 16'h2528;
			5'h04: sine_q15 = 16'h30FC;
			5'h05: sine_q15 = 16'h3C57;
			5'h06: sine_q15 = 16'h471D;
			5'h07: sine_q15 = 16'h5134;
			5'h08: sine_q15 = 16'h5A82;
			5'h09: sine_q15 = 16'h62F2;
			5'h0A: sine_q15 = 16'h6A6E;
			5'h0B: sine_q15 = 16'h70E3;
			5'h0C: sine_q15 = 16'h7642;
			5'h0D: sine_q15 = 16'h7A7D;
			5'h0E: sine_q15 = 16'h7D8A;
			5'h0F: sine_q15 = 16'h7F62;
			default: sine_q15 = 16'h7FFF;
		endcase
	endfunction : sine_q15
endpackage : pm_drive_pkg

// ---- pm_inverter_model.sv ----
// behavioural inverter: bus voltage sensing and modulator gates
// assumes the bench sets the bus level it wants to see
`timescale 1ns/100ps
module pm_inverter_model (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst_b,
	// gate drive from the block
	input wire logic [2:0]  gate_high,
	input wire logic [2:0]  gate_low,
	// requested bus level
	input wire logic [15:0] bus_level,
	// sensed values
	output logic [15:0]     dc_bus_voltage,
	output logic [5:0]      pwm_gates_in,
	output logic            shoot
);
	// complementary legs, never both switches of one leg
	assign pwm_gates_in = 6'h0E;
	// sensing lags one cycle, like a sampled converter
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			dc_bus_voltage <= 16'h0000;
		else
			dc_bus_voltage <= bus_level;
	end
	// shorting the terminals is legal only through one side at a time
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			shoot <= 1'h0;
		else if (|(gate_high & gate_low))
			shoot <= 1'h1;
	end
endmodule : pm_inverter_model

// ---- pm_motor_fieldweak_braking.sv ----
// pm_motor_fieldweak_braking: current-angle decoupler, field weakening,
// regen torque floor, zero vector braking and critical overvoltage.
// assumes all inputs synchronous to core_clk; ctrl_tick pulses once per
// control cycle and pwm_sync once per pwm period.
// Functional notes
// - angle advance grows linearly with current magnitude, slope from angle_slope.
// - clamp angle to angle_advance_max, then split current into d and q.
// - modulation above threshold drives negative d current, limiting modulation.
// - field-weakening gain divided by electrical frequency to keep loop gain flat.
// - loop is a first-order lag set by one integral gain, about 0.25 s.
// - lower threshold setting starts d current injection at lower modulation.
// - stopped drive turns all switches off so the rotor coasts.
// - torque reference floored at minus the regeneration limit.
// - zero vector braking alternates all low-side then all high-side on.
// - zero vector braking entered by request bit 1 or sequencer command 3.
// - bus voltage above critical level sets the critical overvoltage command.
// - critical overvoltage forces low-side zero vector over everything, faults too.
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
module pm_motor_fieldweak_braking
	import pm_drive_pkg::*;
#(
	parameter int DW = 16
) (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_b,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0]    address,
	input  wire logic                 read,
	input  wire logic                 write,
	input  wire logic [31:0]          writedata,
	output logic      [31:0]          readdata,
	output logic                      waitrequest,
	// control-cycle inputs
	input  wire logic                 ctrl_tick,
	input  wire logic                 pwm_sync,
	input  wire logic [DW-1:0]        current_mag,
	input  wire logic [DW-1:0]        modulation_index,
	input  wire logic [DW-1:0]        elec_freq,
	input  wire logic [DW-1:0]        dc_bus_voltage,
	input  wire logic signed [DW-1:0] speed_pi_out,
	input  wire logic [5:0]           pwm_gates_in,
	input  wire logic                 fault,
	// outputs to current loop and inverter
	output logic signed [DW-1:0]      id_cmd,
	output logic signed [DW-1:0]      iq_cmd,
	output logic signed [DW-1:0]      fw_d_current_cmd,
	output logic signed [DW-1:0]      torque_ref,
	output logic [2:0]                gate_high,
	output logic [2:0]                gate_low,
	output logic                      critical_overvoltage_cmd,
	output logic                      irq
);
	logic                 run_bit;
	logic                 zv_req;
	logic [SEQ_W-1:0]     sequencer_command;
	logic [DW-1:0]        angle_slope;
	logic [ANG_W-1:0]     angle_advance_max;
	logic [DW-1:0]        fw_threshold_setting;
	logic [DW-1:0]        fw_integral_gain;
	logic [DW-1:0]        regen_limit;
	logic [DW-1:0]        crit_level;
	logic [IRQ_W-1:0]     irq_status;
	logic [IRQ_W-1:0]     irq_mask;
	drive_mode_e          mode;
	drive_mode_e          next_mode;
	logic                 zv_phase;
	logic                 fw_active;
	logic                 regen_clamp;
	logic                 wr_ack;
	logic                 rd_ack;
	logic [IRQ_W-1:0]     events;

	assign wr_ack = write && !waitrequest;
	assign rd_ack = read && waitrequest;

	// bus handshake: every access answers on the second edge
	// one wait state keeps readdata registered at the cost of a cycle
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= !((read || write) && waitrequest);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			run_bit              <= 1'b0;
			zv_req               <= 1'b0;
			sequencer_command    <= SEQ_STOP;
			angle_slope          <= RST_ANG_SLOPE;
			angle_advance_max    <= RST_ANG_MAX;
			fw_threshold_setting <= RST_FW_THR;
			fw_integral_gain     <= RST_FW_KI;
			regen_limit          <= RST_REGEN;
			crit_level           <= RST_CRIT_LVL;
			irq_mask             <= '0;
		end else if (wr_ack) begin
			unique case (address)
				REG_CTRL: begin
					run_bit           <= writedata[CTRL_RUN];
					zv_req            <= writedata[CTRL_ZV_REQ];
					sequencer_command <=
						writedata[CTRL_SEQ_LSB +: SEQ_W];
				end
				REG_ANG_SLOPE: angle_slope          <= writedata[DW-1:0];
				REG_ANG_MAX:   angle_advance_max    <= writedata[ANG_W-1:0];
				REG_FW_THR:    fw_threshold_setting <= writedata[DW-1:0];
				REG_FW_KI:     fw_integral_gain     <= writedata[DW-1:0];
				REG_REGEN:     regen_limit          <= writedata[DW-1:0];
				REG_CRIT_LVL:  crit_level           <= writedata[DW-1:0];
				REG_IRQ_MASK:  irq_mask             <= writedata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			readdata <= '0;
		end else if (rd_ack) begin
			unique case (address)
				REG_CTRL: readdata <= 32'({sequencer_command, 2'b00,
					zv_req, run_bit});
				REG_ANG_SLOPE: readdata <= 32'(angle_slope);
				REG_ANG_MAX:   readdata <= 32'(angle_advance_max);
				REG_FW_THR:    readdata <= 32'(fw_threshold_setting);
				REG_FW_KI:     readdata <= 32'(fw_integral_gain);
				REG_REGEN:     readdata <= 32'(regen_limit);
				REG_CRIT_LVL:  readdata <= 32'(crit_level);
				REG_STATUS: readdata <= 32'({mode, 1'b0, regen_clamp,
					fw_active, critical_overvoltage_cmd});
				REG_IRQ_STAT:  readdata <= 32'(irq_status);
				REG_IRQ_MASK:  readdata <= 32'(irq_mask);
				// zero-extend: the field is 16 bits wide, upper half reads 0
				REG_FW_ID:     readdata <= 32'(unsigned'(fw_d_current_cmd));
				default:       readdata <= '0;
			endcase
		end
	end

	// current angle decoupler
	logic [2*DW-1:0]  slope_prod;
	logic [ANG_W-1:0] angle_raw;
	logic [ANG_W-1:0] angle_lim;
	logic [4:0]       ang_idx;
	logic [2*DW-1:0]  d_prod;
	logic [2*DW-1:0]  q_prod;
	logic signed [DW+1:0] id_sum;

	always_comb begin
		slope_prod = current_mag * angle_slope;
		// saturate before truncation so a large product cannot wrap small
		if (|slope_prod[2*DW-1:SLOPE_SHIFT+ANG_W]) begin
			angle_raw = '1;
		end else begin
			angle_raw = slope_prod[SLOPE_SHIFT +: ANG_W];
		end
		angle_lim = (angle_raw > angle_advance_max) ?
			angle_advance_max : angle_raw;
		ang_idx = (angle_lim[ANG_W-1:ANG_IDX_LSB] > LUT_TOP) ?
			LUT_TOP : angle_lim[ANG_W-1:ANG_IDX_LSB];
		d_prod = current_mag * sine_q15(ang_idx);
		q_prod = current_mag * sine_q15(LUT_TOP - ang_idx);
		id_sum = (DW+2)'(fw_d_current_cmd) -
			(DW+2)'(d_prod[TRIG_SHIFT +: DW]);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			id_cmd <= '0;
			iq_cmd <= '0;
		end else if (ctrl_tick) begin
			id_cmd <= (id_sum < -(DW+2)'(2**(DW-1))) ?
				DW'(-(2**(DW-1))) : id_sum[DW-1:0];
			// above full-scale magnitude the q share would wrap; saturate it
			if (q_prod[TRIG_SHIFT+DW-1]) begin
				iq_cmd <= {1'b0, {(DW-1){1'b1}}};
			end else begin
				iq_cmd <= $signed({1'b0, q_prod[TRIG_SHIFT +: DW-1]});
			end
		end
	end

	// field weakening integrator with frequency gain modulation
	logic signed [DW:0]     fw_err;
	logic signed [2*DW+1:0] fw_term;
	logic signed [2*DW+1:0] fw_next;
	logic [4:0]             freq_shift;

	function automatic logic [4:0] msb_pos(input logic [DW-1:0] v);
		msb_pos = 5'(FW_FREQ_FLOOR);
		for (int k = FW_FREQ_FLOOR; k < DW; k++) begin
			if (v[k]) begin
				msb_pos = 5'(k);
			end
		end
	endfunction : msb_pos

	always_comb begin
		// positive error means modulation above threshold
		fw_err = $signed({1'b0, modulation_index}) -
			$signed({1'b0, fw_threshold_setting});
		freq_shift = msb_pos(elec_freq) - 5'(FW_FREQ_FLOOR);
		fw_term = ((2*DW+2)'(fw_err) * $signed({1'b0, fw_integral_gain}))
			>>> freq_shift;
		fw_next = (2*DW+2)'(fw_d_current_cmd) - fw_term;
	end

	// only negative d current is ever commanded; integrator clamps at zero
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			fw_d_current_cmd <= '0;
		end else if (mode != MODE_RUN) begin
			fw_d_current_cmd <= '0;
		end else if (ctrl_tick) begin
			if (fw_next > 0) begin
				fw_d_current_cmd <= '0;
			end else if (fw_next < -(2*DW+2)'(2**(DW-1))) begin
				fw_d_current_cmd <= DW'(-(2**(DW-1)));
			end else begin
				fw_d_current_cmd <= fw_next[DW-1:0];
			end
		end
	end

	assign fw_active = fw_d_current_cmd != '0;

	// regeneration floor on the speed loop output
	logic signed [DW:0] regen_floor;
	assign regen_floor = -$signed({1'b0, regen_limit});
	assign regen_clamp = (DW+1)'(speed_pi_out) < regen_floor;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			torque_ref <= '0;
		end else if (ctrl_tick) begin
			torque_ref <= regen_clamp ?
				regen_floor[DW-1:0] : speed_pi_out;
		end
	end

	// drive mode from request bit and sequencer command
	// braking outranks run so a stale run bit cannot cancel a brake
	always_comb begin
		if (zv_req || sequencer_command == SEQ_ZVB) begin
			next_mode = MODE_ZVB;
		end else if (run_bit || sequencer_command == SEQ_RUN) begin
			next_mode = MODE_RUN;
		end else begin
			next_mode = MODE_STOP;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode <= MODE_STOP;
		end else begin
			mode <= next_mode;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			zv_phase <= 1'b0;
		end else if (mode != MODE_ZVB) begin
			zv_phase <= 1'b0;
		end else if (pwm_sync) begin
			zv_phase <= !zv_phase;
		end
	end

	// level compare; the forced vector lasts exactly as long as the bit
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			critical_overvoltage_cmd <= 1'b0;
		end else begin
			critical_overvoltage_cmd <= dc_bus_voltage > crit_level;
		end
	end

	// gate priority: overvoltage, fault, stop, braking, modulator
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gate_high <= '0;
			gate_low  <= '0;
		end else if (critical_overvoltage_cmd) begin
			gate_high <= '0;
			gate_low  <= '1;
		end else if (fault || mode == MODE_STOP) begin
			gate_high <= '0;
			gate_low  <= '0;
		end else if (mode == MODE_ZVB) begin
			gate_high <= {3{zv_phase}};
			gate_low  <= {3{!zv_phase}};
		end else begin
			gate_high <= pwm_gates_in[5:3];
			gate_low  <= pwm_gates_in[2:0];
		end
	end

	// sticky events, write one to clear; a new event beats the clear
	logic crit_q;
	logic fw_q;
	logic regen_q;
	assign events[EV_CRIT_OV] = critical_overvoltage_cmd && !crit_q;
	assign events[EV_FW_ON]   = fw_active && !fw_q;
	assign events[EV_REGEN]   = ctrl_tick && regen_clamp && !regen_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			crit_q  <= 1'b0;
			fw_q    <= 1'b0;
			regen_q <= 1'b0;
		end else begin
			crit_q  <= critical_overvoltage_cmd;
			fw_q    <= fw_active;
			regen_q <= ctrl_tick ? regen_clamp : regen_q;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~((wr_ack &&
				address == REG_IRQ_STAT) ? writedata[IRQ_W-1:0] : '0))
				| events;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			// level output: stays high until the bit is cleared or masked
			irq <= |(irq_status & irq_mask);
		end
	end
endmodule : pm_motor_fieldweak_braking

// ---- pm_motor_fieldweak_braking_tb.sv ----
// self-checking bench for the braking and field-weakening block
// assumes the inverter model feeds bus voltage and modulator gates
`timescale 1ns/100ps
module pm_motor_fieldweak_braking_tb;
	import pm_drive_pkg::*;
	logic               core_clk, rst_b, read, write, waitrequest;
	logic               ctrl_tick, pwm_sync, fault, irq, shoot, ov;
	logic [ADDR_W-1:0]  address;
	logic [31:0]        writedata, readdata, q;
	logic [15:0]        current_mag, modulation_index, elec_freq;
	logic [15:0]        dc_bus_voltage, bus_level;
	logic signed [15:0] speed_pi_out, id_cmd, iq_cmd, fw_cmd, torque_ref;
	logic [5:0]         pwm_gates_in;
	logic [2:0]         gate_high, gate_low;
	int                 errors, n_tests, cycles;
	logic [31:0]        rst_vals [6];

	pm_motor_fieldweak_braking u_pm_motor_fieldweak_braking (
		.core_clk(core_clk), .rst_b(rst_b), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .ctrl_tick(ctrl_tick), .pwm_sync(pwm_sync),
		.current_mag(current_mag), .modulation_index(modulation_index),
		.elec_freq(elec_freq), .dc_bus_voltage(dc_bus_voltage),
		.speed_pi_out(speed_pi_out), .pwm_gates_in(pwm_gates_in),
		.fault(fault), .id_cmd(id_cmd), .iq_cmd(iq_cmd),
		.fw_d_current_cmd(fw_cmd), .torque_ref(torque_ref),
		.gate_high(gate_high), .gate_low(gate_low),
		.critical_overvoltage_cmd(ov), .irq(irq));
	pm_inverter_model u_pm_inverter_model (
		.core_clk(core_clk), .rst_b(rst_b), .gate_high(gate_high),
		.gate_low(gate_low), .bus_level(bus_level),
		.dc_bus_voltage(dc_bus_voltage), .pwm_gates_in(pwm_gates_in),
		.shoot(shoot));

	task close_out;
		if (errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// request held until waitrequest is sampled low
	task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		// only the cycle watchdog ends a wait that never answers
		do begin
			@(posedge core_clk);
		end while (waitrequest !== 1'h0);
		q = readdata;
		read <= 1'h0;
		write <= 1'h0;
	endtask : bus
	task tick(input logic [15:0] m, x, f, s);
		@(posedge core_clk);
		current_mag <= m;
		modulation_index <= x;
		elec_freq <= f;
		speed_pi_out <= s;
		ctrl_tick <= 1'h1;
		@(posedge core_clk);
		ctrl_tick <= 1'h0;
		#1;
	endtask : tick
	task wait_n(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : wait_n

	initial begin
		core_clk = 1'h0;
		forever #4 core_clk = ~core_clk;
	end
	// a hang counts as a mismatch
	always @(posedge core_clk) begin
		cycles++;
		if (cycles > 5000) begin
			errors++;
			close_out();
		end
	end

	initial begin
		{rst_b, read, write, ctrl_tick, pwm_sync, fault} = 6'h00;
		{address, writedata, current_mag, modulation_index} = '0;
		{elec_freq, speed_pi_out} = '0;
		bus_level = 16'h1000;
		{errors, n_tests, cycles} = '0;
		rst_vals = '{RST_ANG_SLOPE, RST_ANG_MAX, RST_FW_THR, RST_FW_KI,
			RST_REGEN, RST_CRIT_LVL};
		repeat (16) @(posedge core_clk);
		rst_b <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			bus(1'h0, REG_ANG_SLOPE + ADDR_W'(4 * i), 32'h0);
			chk(q, rst_vals[i]);
		end
		bus(1'h1, 6'h3C, 32'hFFFF);
		bus(1'h0, 6'h3C, 32'h0);
		chk(q, 32'h0);
		wait_n(3);
		chk({gate_high, gate_low}, 6'h00);
		tick(16'h4000, 16'h0, 16'h0, 16'h0);
		chk({id_cmd}, 16'hD2BF);
		chk({iq_cmd}, 16'h2D41);
		bus(1'h1, REG_ANG_SLOPE, 32'h1);
		tick(16'h2000, 16'h0, 16'h0, 16'h0);
		chk({id_cmd}, 16'hF3C1);
		chk({iq_cmd}, 16'h1D90);
		bus(1'h1, REG_CTRL, 32'h11);
		wait_n(3);
		chk({gate_high, gate_low}, 6'h0E);
		tick(16'h0, 16'h5000, 16'h0, 16'h0);
		chk({fw_cmd}, 16'h0);
		bus(1'h1, REG_FW_THR, 32'h4FFF);
		tick(16'h0, 16'h5000, 16'h0, 16'h0);
		chk({fw_cmd}, 16'hFFF0);
		tick(16'h0, 16'h5000, 16'h0100, 16'h0);
		chk({fw_cmd}, 16'hFFEF);
		bus(1'h0, REG_FW_ID, 32'h0);
		chk(q, 32'hFFEF);
		bus(1'h1, REG_REGEN, 32'h100);
		tick(16'h0, 16'h0, 16'h0, 16'hFC00);
		chk({torque_ref}, 16'hFF00);
		tick(16'h0, 16'h0, 16'h0, 16'hFF80);
		chk({torque_ref}, 16'hFF80);
		for (int i = 0; i < 2; i++) begin
			bus(1'h1, REG_CTRL, i ? 32'h30 : 32'h03);
			wait_n(3);
			chk({gate_high, gate_low}, 6'h07);
			@(posedge core_clk);
			pwm_sync <= 1'h1;
			@(posedge core_clk);
			pwm_sync <= 1'h0;
			wait_n(2);
			chk({gate_high, gate_low}, 6'h38);
			bus(1'h1, REG_CTRL, 32'h11);
		end
		bus(1'h1, REG_CRIT_LVL, 32'h5000);
		fault <= 1'h1;
		wait_n(3);
		chk({gate_high, gate_low}, 6'h00);
		@(posedge core_clk);
		bus_level <= 16'h5001;
		wait_n(4);
		chk(ov, 1'h1);
		bus(1'h0, REG_STATUS, 32'h0);
		chk(q, 32'h11);
		chk({gate_high, gate_low}, 6'h07);
		chk(irq, 1'h0);
		bus(1'h1, REG_IRQ_MASK, 32'h1);
		wait_n(2);
		chk(irq, 1'h1);
		bus(1'h0, REG_IRQ_STAT, 32'h0);
		chk(q, 32'h7);
		chk({gate_high, gate_low}, 6'h07);
		@(posedge core_clk);
		bus_level <= 16'h5000;
		wait_n(4);
		chk(ov, 1'h0);
		chk({gate_high, gate_low}, 6'h00);
		bus(1'h1, REG_IRQ_STAT, 32'h1);
		wait_n(2);
		chk(irq, 1'h0);
		chk(shoot, 1'h0);
		close_out();
	end
endmodule : pm_motor_fieldweak_braking_tb
